// file: design/data_transfer_decoder.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "dt_defines.svh"

module data_transfer_decoder
    import dt_types_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic BYTE_VALID,
    input wire logic [7:0] BYTE_DATA,
    output logic BYTE_READY,
    input wire logic OPERAND_ODD,
    input wire logic [8:0] FLAGS_IN,
    input wire logic [8:0] RESULT_FLAGS,
    input wire logic [8:0] SAVED_FLAGS,
    output logic [8:0] FLAGS_OUT,
    output logic INSN_DONE,
    output logic [3:0] OP_CLASS,
    output logic IS_WORD,
    output logic TO_REG,
    output logic [2:0] REG_FIELD,
    output logic [2:0] RM_FIELD,
    output logic [1:0] MODE,
    output logic [1:0] SEG_FIELD,
    output logic [15:0] DISP,
    output logic [15:0] IMM,
    output logic [7:0] CYCLES,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA
);
    // ************************************************************
    // Decode helpers.
    // ************************************************************
    function automatic op_class_t classify(input logic [7:0] op);
        casez (op)
            8'b1000_10??: classify = OP_MOVE_RM;
            8'b1100_011?: classify = OP_MOVE_IMM_RM;
            8'b1011_????: classify = OP_MOVE_IMM_REG;
            8'b1010_000?: classify = OP_MOVE_MEM_ACC;
            8'b1010_001?: classify = OP_MOVE_ACC_MEM;
            8'b1000_1110: classify = OP_SEG_LOAD;
            8'b1000_1100: classify = OP_SEG_STORE;
            8'b1000_011?: classify = OP_EXCHANGE_RM;
            8'b1001_0???: classify = OP_EXCHANGE_ACC;
            8'b1110_010?: classify = OP_IN_FIXED;
            default: classify = OP_NONE;
        endcase
    endfunction

    // Address clocks for a memory operand of the second byte.
    function automatic logic [7:0] effective_address_cycles(
        input logic [1:0] md, input logic [2:0] rm);
        logic with_disp;
        with_disp = (md != `DT_MODE_NO_DISP);
        if (md == `DT_MODE_REG) begin
            effective_address_cycles = 8'h00;
        end else if (!with_disp && rm == `DT_RM_DIRECT) begin
            effective_address_cycles = `DT_EA_DIRECT;
        end else if (rm[2]) begin
            effective_address_cycles = with_disp ? `DT_EA_BASE_DISP
                                                 : `DT_EA_BASE;
        end else if (rm[1] == rm[0]) begin
            effective_address_cycles = with_disp ? `DT_EA_PAIR_FAST_DISP
                                                 : `DT_EA_PAIR_FAST;
        end else begin
            effective_address_cycles = with_disp ? `DT_EA_PAIR_SLOW_DISP
                                                 : `DT_EA_PAIR_SLOW;
        end
    endfunction

    // ************************************************************
    // State and captured instruction bytes.
    // ************************************************************
    state_t state;
    state_t next_state;
    op_class_t cls;
    op_class_t in_cls;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [15:0] disp_word;
    logic [15:0] imm_word;
    logic ctrl_enable;
    logic [7:0] last_cycles;
    logic [15:0] done_count;
    logic accept;
    logic two_byte_addr;
    logic direct_acc;
    logic word_op;
    logic mem_op;
    logic [7:0] next_cycles;
    logic [1:0] md;
    logic [2:0] rm;
    logic [8:0] applied_flags;
    state_t after_addr;

    assign accept = BYTE_VALID && BYTE_READY;
    assign cls = classify(opcode);
    assign in_cls = classify(BYTE_DATA);
    assign md = modrm[7:6];
    assign rm = modrm[2:0];
    assign direct_acc = (cls == OP_MOVE_MEM_ACC) || (cls == OP_MOVE_ACC_MEM);

    // Direct forms always carry two address bytes.
    assign two_byte_addr = direct_acc || md == `DT_MODE_DISP16 ||
        (md == `DT_MODE_NO_DISP && rm == `DT_RM_DIRECT);
    assign after_addr = (cls == OP_MOVE_IMM_RM) ? S_DATA_LO : S_FINISH;

    // Next state follows the byte layout of the current form.
    always_comb begin
        next_state = state;
        case (state)
            S_OPCODE: begin
                if (accept) begin
                    case (in_cls)
                        OP_MOVE_RM, OP_MOVE_IMM_RM, OP_SEG_LOAD,
                        OP_SEG_STORE, OP_EXCHANGE_RM: next_state = S_MODRM;
                        OP_MOVE_IMM_REG, OP_IN_FIXED: next_state = S_DATA_LO;
                        OP_MOVE_MEM_ACC, OP_MOVE_ACC_MEM: next_state = S_DISP_LO;
                        default: next_state = S_FINISH;
                    endcase
                end
            end
            S_MODRM: begin
                if (accept) begin
                    if (BYTE_DATA[7:6] == `DT_MODE_DISP8 ||
                        BYTE_DATA[7:6] == `DT_MODE_DISP16 ||
                        (BYTE_DATA[7:6] == `DT_MODE_NO_DISP &&
                         BYTE_DATA[2:0] == `DT_RM_DIRECT)) begin
                        next_state = S_DISP_LO;
                    end else begin
                        next_state = after_addr;
                    end
                end
            end
            S_DISP_LO: begin
                if (accept) begin
                    next_state = two_byte_addr ? S_DISP_HI : after_addr;
                end
            end
            S_DISP_HI: begin
                if (accept) begin
                    next_state = after_addr;
                end
            end
            S_DATA_LO: begin
                if (accept) begin
                    // Port number is one byte whatever the width bit says.
                    next_state = (word_op && cls != OP_IN_FIXED) ?
                        S_DATA_HI : S_FINISH;
                end
            end
            S_DATA_HI: begin
                if (accept) begin
                    next_state = S_FINISH;
                end
            end
            S_FINISH: next_state = S_OPCODE;
            default: next_state = S_OPCODE;
        endcase
    end

    // State register and byte handshake; no byte is taken while finishing.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= S_OPCODE;
            BYTE_READY <= 1'b0;
        end else begin
            state <= next_state;
            BYTE_READY <= ctrl_enable && next_state != S_FINISH;
        end
    end

    // Capture of the instruction bytes as they arrive.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            opcode <= 8'h00;
            modrm <= 8'h00;
            disp_word <= 16'h0000;
            imm_word <= 16'h0000;
        end else if (accept) begin
            case (state)
                S_OPCODE: begin
                    opcode <= BYTE_DATA;
                    modrm <= {`DT_MODE_REG, 6'h00};
                    disp_word <= 16'h0000;
                    imm_word <= 16'h0000;
                end
                S_MODRM: modrm <= BYTE_DATA;
                S_DISP_LO: begin
                    if (!direct_acc && md == `DT_MODE_DISP8) begin
                        disp_word <= {{8{BYTE_DATA[7]}}, BYTE_DATA};
                    end else begin
                        disp_word <= {8'h00, BYTE_DATA};
                    end
                end
                S_DISP_HI: disp_word[15:8] <= BYTE_DATA;
                S_DATA_LO: imm_word <= {8'h00, BYTE_DATA};
                S_DATA_HI: imm_word[15:8] <= BYTE_DATA;
                default: opcode <= opcode;
            endcase
        end
    end

    // ************************************************************
    // Clock count of the finished instruction.
    // ************************************************************
    assign word_op = (cls == OP_MOVE_IMM_REG) ? opcode[3] :
        ((cls == OP_SEG_LOAD || cls == OP_SEG_STORE) ? 1'b1 : opcode[0]);
    assign mem_op = direct_acc || (md != `DT_MODE_REG);

    always_comb begin
        case (cls)
            OP_MOVE_RM: begin
                if (!mem_op) next_cycles = `DT_CLK_REG_MOVE;
                else if (opcode[1]) next_cycles = `DT_CLK_MEM_TO_REG;
                else next_cycles = `DT_CLK_REG_TO_MEM;
            end
            OP_MOVE_IMM_RM: next_cycles = `DT_CLK_IMM_TO_RM;
            OP_MOVE_IMM_REG: next_cycles = `DT_CLK_IMM_TO_REG;
            OP_MOVE_MEM_ACC, OP_MOVE_ACC_MEM:
                next_cycles = `DT_CLK_DIRECT_ACC;
            OP_SEG_LOAD: next_cycles = mem_op ? `DT_CLK_MEM_TO_REG
                                              : `DT_CLK_REG_MOVE;
            OP_SEG_STORE: next_cycles = mem_op ? `DT_CLK_REG_TO_MEM
                                               : `DT_CLK_REG_MOVE;
            OP_EXCHANGE_RM: next_cycles = mem_op ? `DT_CLK_EXCH_MEM
                                                 : `DT_CLK_EXCH_REG;
            OP_EXCHANGE_ACC: next_cycles = `DT_CLK_EXCH_ACC;
            OP_IN_FIXED: next_cycles = `DT_CLK_IN_FIXED;
            default: next_cycles = 8'h00;
        endcase
        // Direct accumulator moves already include their address time.
        if (!direct_acc && cls != OP_MOVE_IMM_REG &&
            cls != OP_EXCHANGE_ACC && cls != OP_IN_FIXED && cls != OP_NONE) begin
            next_cycles = next_cycles + effective_address_cycles(md, rm);
        end
        if (mem_op && word_op && OPERAND_ODD && cls != OP_NONE &&
            cls != OP_MOVE_IMM_REG && cls != OP_EXCHANGE_ACC &&
            cls != OP_IN_FIXED) begin
            next_cycles = next_cycles + `DT_ODD_WORD_PENALTY;
        end
    end

    // Every data transfer form leaves all flag columns blank.
    flag_effect u_flags (
        .codes({`DT_FLAG_COUNT{`DT_FLAG_KEEP}}),
        .old_flags(FLAGS_IN),
        .result_flags(RESULT_FLAGS),
        .saved_flags(SAVED_FLAGS),
        .new_flags(applied_flags)
    );

    // ************************************************************
    // Decoded outputs, loaded in the finishing cycle and held until the next; INSN_DONE is high for one cycle only.
    // ************************************************************
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            INSN_DONE <= 1'b0;
            OP_CLASS <= 4'h0;
            IS_WORD <= 1'b0;
            TO_REG <= 1'b0;
            REG_FIELD <= 3'h0;
            RM_FIELD <= 3'h0;
            MODE <= 2'h0;
            SEG_FIELD <= 2'h0;
            DISP <= 16'h0000;
            IMM <= 16'h0000;
            CYCLES <= 8'h00;
            FLAGS_OUT <= 9'h000;
        end else begin
            INSN_DONE <= (state == S_FINISH);
            if (state == S_FINISH) begin
                OP_CLASS <= cls;
                IS_WORD <= word_op;
                TO_REG <= (cls == OP_MOVE_RM) ? opcode[1] :
                    (cls == OP_SEG_LOAD || cls == OP_MOVE_MEM_ACC ||
                     cls == OP_IN_FIXED || cls == OP_MOVE_IMM_REG);
                REG_FIELD <= (cls == OP_MOVE_IMM_REG ||
                    cls == OP_EXCHANGE_ACC) ? opcode[2:0] : modrm[5:3];
                RM_FIELD <= rm;
                MODE <= md;
                SEG_FIELD <= modrm[4:3];
                DISP <= disp_word;
                IMM <= imm_word;
                CYCLES <= next_cycles;
                FLAGS_OUT <= applied_flags;
            end
        end
    end

    // ************************************************************
    // Control port registers.
    // ************************************************************
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_enable <= 1'(`DT_CTRL_RESET);
        end else if (REG_WR && REG_ADDR == `DT_ADDR_CTRL) begin
            ctrl_enable <= REG_WDATA[`DT_CTRL_ENABLE_BIT];
        end
    end

    // A finishing instruction beats a clearing write to the counter.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            last_cycles <= 8'h00;
            done_count <= 16'h0000;
        end else if (state == S_FINISH) begin
            last_cycles <= next_cycles;
            done_count <= done_count + 16'h0001;
        end else if (REG_WR && REG_ADDR == `DT_ADDR_COUNT) begin
            done_count <= 16'h0000;
        end
    end

    // Read data stand in the cycle after the read strobe only.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `DT_ADDR_CTRL: REG_RDATA <= {15'h0000, ctrl_enable};
                `DT_ADDR_STATUS: REG_RDATA <= {9'h000, state, cls};
                `DT_ADDR_CYCLES: REG_RDATA <= {8'h00, last_cycles};
                `DT_ADDR_COUNT: REG_RDATA <= done_count;
                default: REG_RDATA <= 16'h0000;
            endcase
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end
endmodule

// file: shared/dt_defines.svh
`ifndef DT_DEFINES_SVH
`define DT_DEFINES_SVH

// ****************************************************************
// Register map of the control port.
// ****************************************************************
`define DT_ADDR_CTRL 4'h0
`define DT_ADDR_STATUS 4'h1
`define DT_ADDR_CYCLES 4'h2
`define DT_ADDR_COUNT 4'h3
`define DT_CTRL_ENABLE_BIT 0
`define DT_CTRL_RESET 16'h0001

// ****************************************************************
// Flag descriptor codes, three bits per flag column.
// ****************************************************************
`define DT_FLAG_KEEP 3'h0
`define DT_FLAG_CLEAR 3'h1
`define DT_FLAG_SET 3'h2
`define DT_FLAG_RESULT 3'h3
`define DT_FLAG_UNDEF 3'h4
`define DT_FLAG_RESTORE 3'h5
`define DT_FLAG_COUNT 9

// ****************************************************************
// Second byte fields and clock counts.
// ****************************************************************
`define DT_MODE_NO_DISP 2'h0
`define DT_MODE_DISP8 2'h1
`define DT_MODE_DISP16 2'h2
`define DT_MODE_REG 2'h3
`define DT_RM_DIRECT 3'h6
`define DT_EA_DIRECT 8'h06
`define DT_EA_BASE 8'h05
`define DT_EA_BASE_DISP 8'h09
`define DT_EA_PAIR_FAST 8'h07
`define DT_EA_PAIR_SLOW 8'h08
`define DT_EA_PAIR_FAST_DISP 8'h0B
`define DT_EA_PAIR_SLOW_DISP 8'h0C
`define DT_ODD_WORD_PENALTY 8'h04
`define DT_CLK_REG_MOVE 8'h02
`define DT_CLK_MEM_TO_REG 8'h08
`define DT_CLK_REG_TO_MEM 8'h09
`define DT_CLK_IMM_TO_RM 8'h0A
`define DT_CLK_IMM_TO_REG 8'h04
`define DT_CLK_DIRECT_ACC 8'h0A
`define DT_CLK_EXCH_REG 8'h04
`define DT_CLK_EXCH_MEM 8'h11
`define DT_CLK_EXCH_ACC 8'h03
`define DT_CLK_IN_FIXED 8'h0A

`endif

// file: shared/dt_types_pkg.sv
package dt_types_pkg;

    // Byte collection states of the decoder.
    typedef enum logic [2:0] {
        S_OPCODE,
        S_MODRM,
        S_DISP_LO,
        S_DISP_HI,
        S_DATA_LO,
        S_DATA_HI,
        S_FINISH
    } state_t;

    // Instruction forms recognised by the decoder.
    typedef enum logic [3:0] {
        OP_NONE,
        OP_MOVE_RM,
        OP_MOVE_IMM_RM,
        OP_MOVE_IMM_REG,
        OP_MOVE_MEM_ACC,
        OP_MOVE_ACC_MEM,
        OP_SEG_LOAD,
        OP_SEG_STORE,
        OP_EXCHANGE_RM,
        OP_EXCHANGE_ACC,
        OP_IN_FIXED
    } op_class_t;

endpackage

// file: design/flag_effect.sv
`timescale 1ns/1ps
`include "dt_defines.svh"

// ****************************************************************
// Applies one descriptor code to each status flag.
// ****************************************************************
module flag_effect (
    input wire logic [3*`DT_FLAG_COUNT-1:0] codes,
    input wire logic [`DT_FLAG_COUNT-1:0] old_flags,
    input wire logic [`DT_FLAG_COUNT-1:0] result_flags,
    input wire logic [`DT_FLAG_COUNT-1:0] saved_flags,
    output logic [`DT_FLAG_COUNT-1:0] new_flags
);
    genvar i;

    // Undefined flags take the result value; software must not rely on it.
    generate
        for (i = 0; i < `DT_FLAG_COUNT; i = i + 1) begin : g_flag
            always_comb begin
                case (codes[3*i +: 3])
                    `DT_FLAG_CLEAR: new_flags[i] = 1'b0;
                    `DT_FLAG_SET: new_flags[i] = 1'b1;
                    `DT_FLAG_RESULT: new_flags[i] = result_flags[i];
                    `DT_FLAG_UNDEF: new_flags[i] = result_flags[i];
                    `DT_FLAG_RESTORE: new_flags[i] = saved_flags[i];
                    default: new_flags[i] = old_flags[i];
                endcase
            end
        end
    endgenerate
endmodule

// file: testbench/byte_feed.sv
`timescale 1ns/1ps

// ****************************************************************
// Instruction byte source on the far side of the decoder.
// ****************************************************************
module byte_feed (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic ready,
    output logic valid,
    output logic [7:0] data
);
    logic [7:0] pending [$];

    // Queue a byte for delivery, lowest byte of a pair first.
    task automatic push(input logic [7:0] b);
        pending.push_back(b);
    endtask

    // A byte stays offered until taken; in slow mode a gap follows
    // each taken byte. Idle data toggles so stale bytes never look valid.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            valid <= 1'b0;
            data <= 8'h00;
            pending.delete();
        end else if (valid && !ready) begin
            valid <= 1'b1;
        end else if (pending.size() > 0 && !(slow && valid)) begin
            valid <= 1'b1;
            data <= pending.pop_front();
        end else begin
            valid <= 1'b0;
            data <= ~data;
        end
    end
endmodule

// file: testbench/data_transfer_decoder_props.sv
`timescale 1ns/1ps

// ****************************************************************
// Clock counts and flag handling seen at the decoder's outputs.
// ****************************************************************
module dt_checker (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic OPERAND_ODD,
    input wire logic [8:0] FLAGS_IN,
    input wire logic [8:0] FLAGS_OUT,
    input wire logic INSN_DONE,
    input wire logic [3:0] OP_CLASS,
    input wire logic IS_WORD,
    input wire logic [1:0] MODE,
    input wire logic [2:0] RM_FIELD,
    input wire logic [7:0] CYCLES
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Odd address is sampled in the finish cycle, one before the pulse.
    a_flags_kept: assert property (
        INSN_DONE |-> FLAGS_OUT == $past(FLAGS_IN))
        else $error("Flags changed.");
    a_exch_acc_clocks: assert property (
        INSN_DONE && OP_CLASS == 4'd9 |-> CYCLES == 8'h03)
        else $error("Acc exchange count.");
    a_port_in_clocks: assert property (
        INSN_DONE && OP_CLASS == 4'd10 |-> CYCLES == 8'h0A)
        else $error("Port input count.");
    a_imm_reg_clocks: assert property (
        INSN_DONE && OP_CLASS == 4'd3 |-> CYCLES == 8'h04)
        else $error("Imm to reg count.");
    a_direct_acc_clocks: assert property (
        INSN_DONE && (OP_CLASS == 4'd4 || OP_CLASS == 4'd5) |->
        CYCLES == 8'h0A + ((IS_WORD && $past(OPERAND_ODD)) ? 8'h04 : 8'h00))
        else $error("Direct acc count.");
    a_reg_move_clocks: assert property (
        INSN_DONE && OP_CLASS == 4'd1 && MODE == 2'h3 |-> CYCLES == 8'h02)
        else $error("Reg move count.");
    a_exch_reg_clocks: assert property (
        INSN_DONE && OP_CLASS == 4'd8 && MODE == 2'h3 |-> CYCLES == 8'h04)
        else $error("Reg exchange count.");
    a_seg_reg_clocks: assert property (
        INSN_DONE && (OP_CLASS == 4'd6 || OP_CLASS == 4'd7) && MODE == 2'h3
        |-> CYCLES == 8'h02)
        else $error("Segment move count.");
    a_imm_rm_reg: assert property (
        INSN_DONE && OP_CLASS == 4'd2 && MODE == 2'h3 |-> CYCLES == 8'h0A)
        else $error("Imm to r/m count.");
    a_exch_base_mem: assert property (
        INSN_DONE && OP_CLASS == 4'd8 && MODE == 2'h0 && RM_FIELD == 3'h4
        |-> CYCLES == 8'h16 + ((IS_WORD && $past(OPERAND_ODD)) ? 8'h04 : 8'h00))
        else $error("Mem exchange count.");
endmodule

bind data_transfer_decoder dt_checker chk (
    .CLK(CLK), .RSTN(RSTN), .OPERAND_ODD(OPERAND_ODD),
    .FLAGS_IN(FLAGS_IN), .FLAGS_OUT(FLAGS_OUT), .INSN_DONE(INSN_DONE),
    .OP_CLASS(OP_CLASS), .IS_WORD(IS_WORD), .MODE(MODE),
    .RM_FIELD(RM_FIELD), .CYCLES(CYCLES));

// file: testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    typedef struct packed {
        logic [47:0] b;
        logic [2:0] n;
        logic odd;
        logic [3:0] cls;
        logic w;
        logic [7:0] cyc;
        logic [2:0] chk;
        logic [15:0] disp;
        logic [15:0] imm;
    } row_t;

    logic CLK, RSTN, SLOW, BYTE_VALID, BYTE_READY, OPERAND_ODD, INSN_DONE;
    logic IS_WORD, TO_REG, REG_WR, REG_RD;
    logic [7:0] BYTE_DATA, CYCLES;
    logic [8:0] FLAGS_IN, RESULT_FLAGS, SAVED_FLAGS, FLAGS_OUT;
    logic [3:0] OP_CLASS, REG_ADDR;
    logic [2:0] REG_FIELD, RM_FIELD;
    logic [1:0] MODE, SEG_FIELD;
    logic [15:0] DISP, IMM, REG_WDATA, REG_RDATA, rd;
    row_t rows [23];
    int error_cnt, tests_run;

    // ****************************************************************
    // Design and byte source.
    // ****************************************************************
    data_transfer_decoder dut (
        .CLK(CLK), .RSTN(RSTN), .BYTE_VALID(BYTE_VALID),
        .BYTE_DATA(BYTE_DATA), .BYTE_READY(BYTE_READY),
        .OPERAND_ODD(OPERAND_ODD), .FLAGS_IN(FLAGS_IN),
        .RESULT_FLAGS(RESULT_FLAGS), .SAVED_FLAGS(SAVED_FLAGS),
        .FLAGS_OUT(FLAGS_OUT), .INSN_DONE(INSN_DONE), .OP_CLASS(OP_CLASS),
        .IS_WORD(IS_WORD), .TO_REG(TO_REG), .REG_FIELD(REG_FIELD),
        .RM_FIELD(RM_FIELD), .MODE(MODE), .SEG_FIELD(SEG_FIELD),
        .DISP(DISP), .IMM(IMM), .CYCLES(CYCLES), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA));
    byte_feed src (.clk(CLK), .rstn(RSTN), .slow(SLOW),
        .ready(BYTE_READY), .valid(BYTE_VALID), .data(BYTE_DATA));

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        @(negedge CLK);
        d = REG_RDATA;
    endtask

    // Bounded wait; a missing pulse shows up as a mismatch.
    task automatic wait_done();
        int k;
        k = 0;
        @(negedge CLK);
        while (INSN_DONE !== 1'b1 && k < 40) begin
            @(negedge CLK);
            k++;
        end
        check(16'(INSN_DONE), 16'h0001);
    endtask

    task automatic run_row(input row_t r, input int i);
        int k;
        @(posedge CLK);
        OPERAND_ODD <= r.odd;
        FLAGS_IN <= 9'(i) ^ 9'h0A5;
        RESULT_FLAGS <= ~(9'(i) ^ 9'h0A5);
        SAVED_FLAGS <= 9'(i * 3);
        SLOW <= 1'(i % 2);
        @(negedge CLK);
        for (k = 0; k < int'(r.n); k++)
            src.push(r.b[47 - 8 * k -: 8]);
        wait_done();
        check(16'(OP_CLASS), 16'(r.cls));
        check(16'(CYCLES), 16'(r.cyc));
        check(16'(FLAGS_OUT), 16'(9'(i) ^ 9'h0A5));
        if (r.chk[2])
            check(16'(IS_WORD), 16'(r.w));
        if (r.chk[0])
            check(DISP, r.disp);
        if (r.chk[1])
            check(IMM, r.imm);
    endtask

    // Free-running processor clock.
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // Cuts a hang short.
    initial begin
        repeat (5000) @(posedge CLK);
        error_cnt++;
        tally_and_finish();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        {RSTN, SLOW, OPERAND_ODD, REG_WR, REG_RD} = 5'h00;
        {FLAGS_IN, RESULT_FLAGS, SAVED_FLAGS} = 27'h000_0000;
        {REG_ADDR, REG_WDATA} = 20'h0_0000;
        error_cnt = 0;
        tests_run = 0;
        rows = '{
        '{48'h8B07_0000_0000, 3'd2, 1'b0, 4'h1, 1'b1, 8'h0D, 3'h4, 16'h0, 16'h0},
        '{48'h8947_F000_0000, 3'd3, 1'b1, 4'h1, 1'b1, 8'h16, 3'h5, 16'hFFF0, 16'h0},
        '{48'h88D8_0000_0000, 3'd2, 1'b0, 4'h1, 1'b0, 8'h02, 3'h4, 16'h0, 16'h0},
        '{48'h8A80_3412_0000, 3'd4, 1'b1, 4'h1, 1'b0, 8'h13, 3'h5, 16'h1234, 16'h0},
        '{48'h8B02_0000_0000, 3'd2, 1'b0, 4'h1, 1'b1, 8'h10, 3'h4, 16'h0, 16'h0},
        '{48'h8B03_0000_0000, 3'd2, 1'b0, 4'h1, 1'b1, 8'h0F, 3'h4, 16'h0, 16'h0},
        '{48'h8B41_0500_0000, 3'd3, 1'b0, 4'h1, 1'b1, 8'h14, 3'h5, 16'h0005, 16'h0},
        '{48'hC706_0020_3412, 3'd6, 1'b0, 4'h2, 1'b1, 8'h10, 3'h7, 16'h2000,
            16'h1234},
        '{48'hC6C0_5A00_0000, 3'd3, 1'b0, 4'h2, 1'b0, 8'h0A, 3'h6, 16'h0, 16'h005A},
        '{48'hB8CD_AB00_0000, 3'd3, 1'b0, 4'h3, 1'b1, 8'h04, 3'h6, 16'h0, 16'hABCD},
        '{48'hB17F_0000_0000, 3'd2, 1'b0, 4'h3, 1'b0, 8'h04, 3'h6, 16'h0, 16'h007F},
        '{48'hA100_3000_0000, 3'd3, 1'b1, 4'h4, 1'b1, 8'h0E, 3'h5, 16'h3000, 16'h0},
        '{48'hA201_3000_0000, 3'd3, 1'b1, 4'h5, 1'b0, 8'h0A, 3'h5, 16'h3001, 16'h0},
        '{48'h8ED8_0000_0000, 3'd2, 1'b0, 4'h6, 1'b1, 8'h02, 3'h4, 16'h0, 16'h0},
        '{48'h8E1E_0040_0000, 3'd4, 1'b0, 4'h6, 1'b1, 8'h0E, 3'h5, 16'h4000, 16'h0},
        '{48'h8C06_0040_0000, 3'd4, 1'b1, 4'h7, 1'b1, 8'h13, 3'h5, 16'h4000, 16'h0},
        '{48'h8CC0_0000_0000, 3'd2, 1'b0, 4'h7, 1'b1, 8'h02, 3'h4, 16'h0, 16'h0},
        '{48'h87D8_0000_0000, 3'd2, 1'b0, 4'h8, 1'b1, 8'h04, 3'h4, 16'h0, 16'h0},
        '{48'h8704_0000_0000, 3'd2, 1'b1, 4'h8, 1'b1, 8'h1A, 3'h4, 16'h0, 16'h0},
        '{48'h9100_0000_0000, 3'd1, 1'b0, 4'h9, 1'b0, 8'h03, 3'h0, 16'h0, 16'h0},
        '{48'hE560_0000_0000, 3'd2, 1'b0, 4'hA, 1'b1, 8'h0A, 3'h6, 16'h0, 16'h0060},
        '{48'hE461_0000_0000, 3'd2, 1'b0, 4'hA, 1'b0, 8'h0A, 3'h6, 16'h0, 16'h0061},
        '{48'hF400_0000_0000, 3'd1, 1'b0, 4'h0, 1'b0, 8'h00, 3'h0, 16'h0, 16'h0}};
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        reg_rd(4'h0, rd);
        check(rd, 16'h0001);
        foreach (rows[i])
            run_row(rows[i], i);
        reg_rd(4'h2, rd);
        check(rd, 16'h0000);
        reg_rd(4'h3, rd);
        check(rd, 16'h0017);
        reg_wr(4'h3, 16'hFFFF);
        reg_rd(4'h3, rd);
        check(rd, 16'h0000);
        reg_rd(4'h7, rd);
        check(rd, 16'h0000);
        // Two instructions offered back to back with no gap.
        @(posedge CLK);
        SLOW <= 1'b0;
        OPERAND_ODD <= 1'b0;
        @(negedge CLK);
        src.push(8'h8B);
        src.push(8'hD8);
        src.push(8'h93);
        wait_done();
        check(16'(CYCLES), 16'h0002);
        check(16'({TO_REG, MODE, SEG_FIELD, RM_FIELD}), 16'h00F8);
        check(16'(FLAGS_OUT), 16'h00B3);
        wait_done();
        check(16'(OP_CLASS), 16'h0009);
        check(16'(REG_FIELD), 16'h0003);
        // Disabled decoding refuses bytes.
        reg_wr(4'h0, 16'h0000);
        @(negedge CLK);
        src.push(8'h90);
        repeat (4) begin
            @(negedge CLK);
            check(16'(BYTE_READY | INSN_DONE), 16'h0000);
        end
        reg_wr(4'h0, 16'h0001);
        wait_done();
        check(16'(CYCLES), 16'h0003);
        // Reset mid-instruction leaves no trace.
        @(negedge CLK);
        src.push(8'hC7);
        src.push(8'h06);
        repeat (2) @(posedge CLK);
        RSTN <= 1'b0;
        @(negedge CLK);
        check(16'(OP_CLASS | CYCLES | BYTE_READY), 16'h0000);
        @(posedge CLK);
        RSTN <= 1'b1;
        run_row(rows[19], 19);
        tally_and_finish();
    end
endmodule
